/* File: rtl/seq_defines.svh */
// Constants for the program sequencer and core state block.
// Assumes inclusion by bare name from rtl/ sources.
// Contract
// - Ten-bit fetch counter advances by instruction length after non-branching instructions.
// - Taken jumps load the fetch counter with the operand destination.
// - Call saves the fetch counter into the return store, then loads destination.
// - Return after a call reloads the fetch counter from the return store.
// - Reset clears the fetch counter to zero.
// - One-bit call depth pointer increments on call, decrements on return.
// - Reset clears the call depth pointer.
// - Depth overflow or underflow forces an internal reset, fetch counter to zero.
// - Only call and return change the call depth pointer.
// - Return store is ten bits; low eight bits share RAM word fifteen.
// - Return store keeps its value after return and across reset.
// - Data access to word fifteen may leave store upper two bits undefined.
// - Program ROM is 512 words of ten bits, addressed by fetch counter.
// - Addresses 3EAH through 3FFH are a reserved test area.
// - Fetch from unmounted or test area returns the counter to zero.
// - Thirty-two four-bit RAM words, also accessible as eight-bit pairs.
// - Reset clears RAM word zero pair; other words keep their contents.
// - Table pointer is control bits 5:4 over RAM word zero pair.
// - Table pointer low eight bits read zero after reset; bits 9:8 follow control bits 5:4.
// - Four-bit accumulator is not initialised by reset.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
`define PC_W 10
`define PC_RESET 10'h000
`define ROM_DEPTH 512
`define ROM_AW 9
`define ROM_W 10
`define TEST_LO 10'h3EA
`define TEST_HI 10'h3FF
`define MOUNT_LIMIT 10'h200
`define RAM_DEPTH 32
`define RAM_AW 5
`define RAM_W 4
`define RAM_WORD_ZERO 5'h00
`define RAM_WORD_ONE 5'h01
`define RAM_WORD_FIFTEEN 5'h0F
`define RAM_WORD_FIFTEEN_HI 5'h1F
`define DP_HI_LSB 4
`define DP_HI_MSB 5
`define DEPTH_RESET 1'h0
`endif

/* File: rtl/seq_pkg.sv */
// Types shared by the sequencer files.
// Assumes the defines header is compiled first.
package seq_pkg;
  typedef enum logic [2:0] {
    OP_STEP,
    OP_BRANCH,
    OP_CALL,
    OP_RETURN,
    OP_TABLE_READ
  } op_kind_type;
endpackage : seq_pkg

/* File: rtl/seq_mem_if.sv */
// Interface carrying RAM access between the sequencer and the data memory.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface seq_mem_if;
  logic [4:0] addr;
  logic wr_en;
  logic pair_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] ptr_low;
  logic [7:0] stash_low;
  logic stash_wr;
  logic [7:0] stash_wdata;
  modport core (output addr, wr_en, pair_en, wdata, stash_wr, stash_wdata,
                input rdata, ptr_low, stash_low);
  modport mem (input addr, wr_en, pair_en, wdata, stash_wr, stash_wdata,
               output rdata, ptr_low, stash_low);
endinterface : seq_mem_if

/* File: rtl/seq_data_ram.sv */
// Thirty-two word data RAM with pair access and a shared return-store slot.
// Assumes clock enable already gates the core; reset clears only word zero pair.
`timescale 1ns/1ps
`include "seq_defines.svh"
module seq_data_ram (
  input wire logic clk_sys_i, // System clock
  input wire logic srst_i, // Sync reset
  input wire logic ce_i, // Clock enable
  seq_mem_if.mem mem // Core side
);
  logic [3:0] ram_reg [0:31];
  logic [4:0] pair_hi;
  assign pair_hi = {1'b1, mem.addr[3:0]};
  // Pair reads take low nibble from bank 0, high nibble from bank 1
  assign mem.rdata = mem.pair_en ? {ram_reg[pair_hi], ram_reg[{1'b0, mem.addr[3:0]}]}
                                 : {4'h0, ram_reg[mem.addr]};
  assign mem.ptr_low = {ram_reg[`RAM_WORD_ONE ^ 5'h11], ram_reg[`RAM_WORD_ZERO]};
  assign mem.stash_low = {ram_reg[`RAM_WORD_FIFTEEN_HI], ram_reg[`RAM_WORD_FIFTEEN]};
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ram_reg[`RAM_WORD_ZERO] <= 4'h0;
      ram_reg[`RAM_WORD_ONE ^ 5'h11] <= 4'h0;
    end else if (ce_i) begin
      if (mem.stash_wr) begin
        ram_reg[`RAM_WORD_FIFTEEN] <= mem.stash_wdata[3:0];
        ram_reg[`RAM_WORD_FIFTEEN_HI] <= mem.stash_wdata[7:4];
      end else if (mem.wr_en) begin
        if (mem.pair_en) begin
          ram_reg[{1'b0, mem.addr[3:0]}] <= mem.wdata[3:0];
          ram_reg[pair_hi] <= mem.wdata[7:4];
        end else begin
          ram_reg[mem.addr] <= mem.wdata[3:0];
        end
      end
    end
  end
endmodule : seq_data_ram

/* File: rtl/seq_core.sv */
// Program sequencer: fetch counter, call depth, return store, ROM, table pointer, accumulator.
// Assumes a decoder outside presents one operation per enabled cycle.
`timescale 1ns/1ps
`include "seq_defines.svh"
module seq_core (
  input wire logic clk_sys_i, // System clock, 100 MHz
  input wire logic srst_i, // Sync reset, active high
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic op_valid_i, // Operation present this cycle
  input wire seq_pkg::op_kind_type op_kind_i, // Operation kind
  input wire logic [1:0] op_len_i, // Instruction length in words
  input wire logic branch_cond_i, // Branch condition holds
  input wire logic [9:0] op_target_i, // Branch or call destination
  input wire logic ram_wr_i, // Data RAM write
  input wire logic ram_pair_i, // Eight-bit pair access
  input wire logic [4:0] ram_addr_i, // Data RAM address
  input wire logic [7:0] ram_wdata_i, // Data RAM write data
  input wire logic [1:0] dp_high_i, // Control register bits 5:4
  input wire logic acc_wr_i, // Accumulator load
  input wire logic [3:0] acc_wdata_i, // Accumulator load data
  input wire logic rom_wr_i, // ROM image load
  input wire logic [8:0] rom_waddr_i, // ROM image address
  input wire logic [9:0] rom_wdata_i, // ROM image word
  output logic [9:0] fetch_addr_o, // Current fetch counter
  output logic [9:0] fetch_word_o, // ROM word at fetch counter
  output logic [9:0] table_word_o, // ROM word at table pointer
  output logic [9:0] table_ptr_o, // Table-read pointer
  output logic [7:0] ram_rdata_o, // Data RAM read data
  output logic [3:0] acc_o, // Accumulator
  output logic call_depth_o, // Call depth pointer
  output logic [9:0] return_addr_o, // Return address store
  output logic internal_reset_o // Internal reset pulse
);
  seq_mem_if mem_bus ();

  logic [9:0] next_fetch_counter_reg;
  logic [9:0] next_fetch_counter_next;
  logic call_depth_pointer_reg;
  logic [1:0] return_store_hi_reg;
  logic [3:0] acc_reg;
  logic internal_reset_reg;
  logic fault;
  logic [9:0] rom_reg [0:511];
  logic [9:0] fetch_word_reg;
  logic [9:0] table_word_reg;
  logic [9:0] return_address_store;
  logic [9:0] table_read_pointer;
  logic do_call;
  logic do_return;

  // Addresses past the mounted ROM or inside the test area are illegal
  function automatic logic addr_illegal(input logic [9:0] a);
    addr_illegal = (a >= `MOUNT_LIMIT) || ((a >= `TEST_LO) && (a <= `TEST_HI));
  endfunction : addr_illegal

  assign do_call = op_valid_i && (op_kind_i == seq_pkg::OP_CALL);
  assign do_return = op_valid_i && (op_kind_i == seq_pkg::OP_RETURN);

  // Nested call or return at depth zero faults: counter and depth return to zero, internal reset pulses
  assign fault = (do_call && call_depth_pointer_reg) || (do_return && !call_depth_pointer_reg);

  always_comb begin
    next_fetch_counter_next = next_fetch_counter_reg;
    if (fault) begin
      next_fetch_counter_next = `PC_RESET;
    end else if (addr_illegal(next_fetch_counter_reg)) begin
      next_fetch_counter_next = `PC_RESET;
    end else if (op_valid_i) begin
      unique case (op_kind_i)
        seq_pkg::OP_BRANCH: begin
          if (branch_cond_i) begin
            next_fetch_counter_next = op_target_i;
          end else begin
            next_fetch_counter_next = next_fetch_counter_reg + {8'h00, op_len_i};
          end
        end
        seq_pkg::OP_CALL: next_fetch_counter_next = op_target_i;
        seq_pkg::OP_RETURN: next_fetch_counter_next = return_address_store;
        seq_pkg::OP_STEP, seq_pkg::OP_TABLE_READ: begin
          next_fetch_counter_next = next_fetch_counter_reg + {8'h00, op_len_i};
        end
        default: next_fetch_counter_next = `PC_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      next_fetch_counter_reg <= `PC_RESET;
    end else if (ce_i) begin
      next_fetch_counter_reg <= next_fetch_counter_next;
    end
  end

  // Depth changes only through call and return
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      call_depth_pointer_reg <= `DEPTH_RESET;
    end else if (ce_i) begin
      if (fault) begin
        call_depth_pointer_reg <= `DEPTH_RESET;
      end else if (do_call) begin
        call_depth_pointer_reg <= 1'b1;
      end else if (do_return) begin
        call_depth_pointer_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      internal_reset_reg <= 1'b0;
    end else if (ce_i) begin
      internal_reset_reg <= fault;
    end
  end

  // Upper store bits survive reset; no reset branch on purpose
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && !srst_i) begin
      if (do_call && !fault) begin
        return_store_hi_reg <= next_fetch_counter_reg[9:8];
      end else if (ram_wr_i && ({1'b0, ram_addr_i[3:0]} == `RAM_WORD_FIFTEEN)) begin
        return_store_hi_reg <= 2'h0;
      end
    end
  end

  assign mem_bus.stash_wr = do_call && !fault;
  assign mem_bus.stash_wdata = next_fetch_counter_reg[7:0];
  assign mem_bus.addr = ram_addr_i;
  assign mem_bus.wr_en = ram_wr_i && !srst_i;
  assign mem_bus.pair_en = ram_pair_i;
  assign mem_bus.wdata = ram_wdata_i;
  assign return_address_store = {return_store_hi_reg, mem_bus.stash_low};
  assign table_read_pointer = {dp_high_i, mem_bus.ptr_low};

  seq_data_ram u_data_ram (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .mem(mem_bus)
  );

  // Accumulator left uninitialised by reset
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && acc_wr_i) begin
      acc_reg <= acc_wdata_i;
    end
  end

  // ROM image is loaded from the ports; only the low nine address bits decode
  always_ff @(posedge clk_sys_i) begin
    if (rom_wr_i) begin
      rom_reg[rom_waddr_i] <= rom_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fetch_word_reg <= 10'h000;
      table_word_reg <= 10'h000;
    end else if (ce_i) begin
      fetch_word_reg <= addr_illegal(next_fetch_counter_next) ? 10'h000
                        : rom_reg[next_fetch_counter_next[8:0]];
      table_word_reg <= addr_illegal(table_read_pointer) ? 10'h000
                        : rom_reg[table_read_pointer[8:0]];
    end
  end

  assign fetch_addr_o = next_fetch_counter_reg;
  assign fetch_word_o = fetch_word_reg;
  assign table_word_o = table_word_reg;
  assign table_ptr_o = table_read_pointer;
  assign ram_rdata_o = mem_bus.rdata;
  assign acc_o = acc_reg;
  assign call_depth_o = call_depth_pointer_reg;
  assign return_addr_o = return_address_store;
  assign internal_reset_o = internal_reset_reg;
endmodule : seq_core

/* File: sim/seq_core_checker.sv */
// Concurrent checks on the sequencer core ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module seq_core_checker (
  input wire logic clk_sys_i, // Clock
  input wire logic srst_i, // Reset
  input wire logic ce_i, // Enable
  input wire logic op_valid_i, // Op present
  input wire seq_pkg::op_kind_type op_kind_i, // Op kind
  input wire logic [1:0] op_len_i, // Length
  input wire logic branch_cond_i, // Condition
  input wire logic [9:0] op_target_i, // Destination
  input wire logic [1:0] dp_high_i, // Pointer high bits
  input wire logic [9:0] fetch_addr_o, // Fetch counter
  input wire logic [9:0] table_ptr_o, // Table pointer
  input wire logic call_depth_o, // Depth
  input wire logic [9:0] return_addr_o, // Return store
  input wire logic internal_reset_o // Fault pulse
);
  logic go;
  logic legal;
  logic fault;
  logic is_call;
  logic is_ret;
  assign go = ce_i && op_valid_i;
  assign legal = fetch_addr_o < 10'h200;
  assign is_call = op_kind_i == seq_pkg::OP_CALL;
  assign is_ret = op_kind_i == seq_pkg::OP_RETURN;
  // Faulting op wins over the illegal-address check
  assign fault = go && ((is_call && call_depth_o) || (is_ret && !call_depth_o));
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  reset_clears_a:
    assert property (disable iff (1'b0) srst_i |=> fetch_addr_o == 10'h000 && !call_depth_o) else $error("reset state");
  step_advance_a:
    assert property (go && op_kind_i == seq_pkg::OP_STEP && legal |=> fetch_addr_o == $past(fetch_addr_o) + 10'($past(op_len_i)))
    else $error("step advance");
  branch_load_a:
    assert property (go && op_kind_i == seq_pkg::OP_BRANCH && branch_cond_i && legal |=> fetch_addr_o == $past(op_target_i))
    else $error("branch target");
  call_save_a:
    assert property (go && is_call && !call_depth_o && legal |=> fetch_addr_o == $past(op_target_i) && call_depth_o
      && return_addr_o == $past(fetch_addr_o)) else $error("call save");
  return_load_a:
    assert property (go && is_ret && call_depth_o && legal |=> fetch_addr_o == $past(return_addr_o) && !call_depth_o
      && $stable(return_addr_o)) else $error("return load");
  depth_fault_a:
    assert property (fault |=> fetch_addr_o == 10'h000 && !call_depth_o && internal_reset_o)
    else $error("depth fault");
  fault_pulse_a:
    assert property (ce_i && !fault |=> !internal_reset_o) else $error("stray fault pulse");
  depth_only_a:
    assert property (!(go && (is_call || is_ret)) |=> $stable(call_depth_o)) else $error("depth changed");
  illegal_addr_a:
    assert property (go && !legal && !fault |=> fetch_addr_o == 10'h000) else $error("illegal address kept");
  table_high_a:
    assert property (table_ptr_o[9:8] == dp_high_i) else $error("table pointer high bits");
  table_reset_a:
    assert property (disable iff (1'b0) srst_i |=> table_ptr_o[7:0] == 8'h00) else $error("table pointer reset");
  ce_freeze_a:
    assert property (!ce_i |=> $stable(fetch_addr_o) && $stable(call_depth_o)) else $error("enable freeze");
endmodule : seq_core_checker

bind seq_core seq_core_checker chk (.*);

/* File: sim/seq_core_tb.sv */
// Self-checking bench for the sequencer core.
// Assumes the defines header and package are compiled first.
`timescale 1ns/1ps
module seq_core_tb;
  typedef struct {seq_pkg::op_kind_type k; logic [1:0] len; logic c; logic [9:0] t; logic [9:0] a; logic d;} row_type;
  logic clk_sys_i, srst_i, ce_i, op_valid_i, branch_cond_i, ram_wr_i, ram_pair_i, acc_wr_i, rom_wr_i;
  seq_pkg::op_kind_type op_kind_i;
  logic [1:0] op_len_i, dp_high_i;
  logic [9:0] op_target_i, rom_wdata_i, fetch_addr_o, fetch_word_o, table_word_o, table_ptr_o, return_addr_o;
  logic [4:0] ram_addr_i;
  logic [7:0] ram_wdata_i, ram_rdata_o;
  logic [3:0] acc_wdata_i, acc_o;
  logic [8:0] rom_waddr_i;
  logic call_depth_o, internal_reset_o;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  row_type rows [8];
  seq_core uut (.*);
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test;
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Generous ceiling, the run needs well under a hundred cycles
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic op(input seq_pkg::op_kind_type k, input logic [1:0] len, input logic c, input logic [9:0] t);
    op_valid_i = 1'b1;
    op_kind_i = k;
    op_len_i = len;
    branch_cond_i = c;
    op_target_i = t;
    // Valid stays up so back-to-back ops never toggle it in one step
    tick();
  endtask : op
  // Address and pair stay up afterwards so the read can be checked
  task automatic ram(input logic [4:0] a, input logic [7:0] d);
    op_valid_i = 1'b0;
    ram_wr_i = 1'b1;
    ram_pair_i = 1'b1;
    ram_addr_i = a;
    ram_wdata_i = d;
    tick();
    ram_wr_i = 1'b0;
  endtask : ram
  initial begin
    {srst_i, ce_i} = 2'h3;
    {op_valid_i, branch_cond_i, ram_wr_i, ram_pair_i, acc_wr_i, rom_wr_i} = 6'h00;
    op_kind_i = seq_pkg::OP_STEP;
    {op_len_i, dp_high_i, op_target_i, rom_wdata_i, rom_waddr_i} = 33'h0;
    {ram_addr_i, ram_wdata_i, acc_wdata_i} = 17'h0;
    rows[0] = '{seq_pkg::OP_STEP, 2'h1, 1'b0, 10'h000, 10'h001, 1'b0};
    rows[1] = '{seq_pkg::OP_STEP, 2'h2, 1'b0, 10'h000, 10'h003, 1'b0};
    rows[2] = '{seq_pkg::OP_BRANCH, 2'h1, 1'b0, 10'h050, 10'h004, 1'b0};
    rows[3] = '{seq_pkg::OP_BRANCH, 2'h1, 1'b1, 10'h050, 10'h050, 1'b0};
    rows[4] = '{seq_pkg::OP_CALL, 2'h1, 1'b1, 10'h120, 10'h120, 1'b1};
    rows[5] = '{seq_pkg::OP_STEP, 2'h3, 1'b0, 10'h000, 10'h123, 1'b1};
    rows[6] = '{seq_pkg::OP_RETURN, 2'h1, 1'b0, 10'h000, 10'h050, 1'b0};
    rows[7] = '{seq_pkg::OP_BRANCH, 2'h1, 1'b1, 10'h1FF, 10'h1FF, 1'b0};
    repeat (10) tick();
    srst_i = 1'b0;
    foreach (rows[i]) begin
      op(rows[i].k, rows[i].len, rows[i].c, rows[i].t);
      chk(fetch_addr_o, rows[i].a);
      chk(10'(call_depth_o), 10'(rows[i].d));
    end
    chk(return_addr_o, 10'h050);
    // Enable low must freeze the counter even with an op present
    ce_i = 1'b0;
    op(seq_pkg::OP_STEP, 2'h1, 1'b0, 10'h000);
    ce_i = 1'b1;
    chk(fetch_addr_o, 10'h1FF);
    op(seq_pkg::OP_STEP, 2'h1, 1'b0, 10'h000);
    chk(fetch_word_o, 10'h000);
    op(seq_pkg::OP_STEP, 2'h1, 1'b0, 10'h000);
    chk(fetch_addr_o, 10'h000);
    op(seq_pkg::OP_BRANCH, 2'h1, 1'b1, 10'h3EA);
    op(seq_pkg::OP_STEP, 2'h2, 1'b0, 10'h000);
    chk(fetch_addr_o, 10'h000);
    op(seq_pkg::OP_STEP, 2'h2, 1'b0, 10'h000);
    op(seq_pkg::OP_CALL, 2'h1, 1'b1, 10'h100);
    // Fault pulse rises at the same edge that clears the counter
    for (int i = 0; i < 2; i++) begin
      op(i ? seq_pkg::OP_RETURN : seq_pkg::OP_CALL, 2'h1, 1'b1, 10'h180);
      chk(fetch_addr_o, 10'h000);
      chk(10'(call_depth_o), 10'h000);
      chk(10'(internal_reset_o), 10'h001);
      op(seq_pkg::OP_STEP, 2'h2, 1'b0, 10'h000);
      chk(10'(internal_reset_o), 10'h000);
    end
    chk(return_addr_o, 10'h002);
    op_valid_i = 1'b0;
    rom_wr_i = 1'b1;
    rom_waddr_i = 9'h005;
    rom_wdata_i = 10'h2A5;
    tick();
    rom_wr_i = 1'b0;
    op(seq_pkg::OP_BRANCH, 2'h1, 1'b1, 10'h005);
    chk(fetch_word_o, 10'h2A5);
    ram(5'h00, 8'h05);
    chk(table_ptr_o, 10'h005);
    op(seq_pkg::OP_TABLE_READ, 2'h1, 1'b0, 10'h000);
    op_valid_i = 1'b0;
    tick();
    chk(table_word_o, 10'h2A5);
    dp_high_i = 2'h1;
    tick();
    chk(table_ptr_o, 10'h105);
    dp_high_i = 2'h0;
    ram(5'h03, 8'h9A);
    chk(10'(ram_rdata_o), 10'h09A);
    // Call from above 0x0FF so the data write below has upper bits to clear
    op(seq_pkg::OP_BRANCH, 2'h1, 1'b1, 10'h1C4);
    op(seq_pkg::OP_CALL, 2'h1, 1'b1, 10'h010);
    chk(return_addr_o, 10'h1C4);
    op(seq_pkg::OP_RETURN, 2'h1, 1'b0, 10'h000);
    chk(fetch_addr_o, 10'h1C4);
    ram(5'h0F, 8'hC3);
    chk(return_addr_o, 10'h0C3);
    acc_wr_i = 1'b1;
    acc_wdata_i = 4'h7;
    tick();
    acc_wr_i = 1'b0;
    srst_i = 1'b1;
    tick();
    srst_i = 1'b0;
    chk(fetch_addr_o, 10'h000);
    chk(10'(call_depth_o), 10'h000);
    chk(return_addr_o, 10'h0C3);
    chk(table_ptr_o, 10'h000);
    chk(10'(acc_o), 10'h007);
    ram_addr_i = 5'h03;
    tick();
    chk(10'(ram_rdata_o), 10'h09A);
    ram_addr_i = 5'h00;
    tick();
    chk(10'(ram_rdata_o), 10'h000);
    end_of_test();
  end
endmodule : seq_core_tb
